/* hw/dtc_pkg.sv */
// Constants for the dual timer/counter block: register indices, fields,
// reset values and timing counts.
// Assumes AHB-Lite byte addresses equal to four times a register index.
package dtc_pkg;
    // Register indices, byte address is four times the index
    localparam logic [7:0] IDX_CTRL   = 8'h88;
    localparam logic [7:0] IDX_MODE   = 8'h89;
    localparam logic [7:0] IDX_LOW0   = 8'h8A;
    localparam logic [7:0] IDX_LOW1   = 8'h8B;
    localparam logic [7:0] IDX_HIGH0  = 8'h8C;
    localparam logic [7:0] IDX_HIGH1  = 8'h8D;
    localparam logic [7:0] IDX_AUX    = 8'h8F;

    // Mode register fields, timer 1 sits one nibble higher
    localparam int MODE_LO_POS   = 0;
    localparam int FSEL_POS      = 2;
    localparam int GATE_POS      = 3;
    localparam int TIMER_STRIDE  = 4;
    // Aux mode register: top mode bit per timer
    localparam int AUX_M2_POS    = 0;
    // Control register fields
    localparam int CTRL_TEN0_POS = 0;
    localparam int CTRL_TEN1_POS = 1;
    localparam int CTRL_RUN0_POS = 4;
    localparam int CTRL_FLG0_POS = 5;
    localparam int CTRL_RUN1_POS = 6;
    localparam int CTRL_FLG1_POS = 7;

    localparam logic [7:0] MODE_RST  = 8'h00;
    localparam logic [7:0] AUX_RST   = 8'h00;
    localparam logic [7:0] CTRL_RST  = 8'h00;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [7:0] AUX_MASK  = 8'h11;

    // Machine cycle length in clocks
    localparam int MC_CLKS = 2;

    // Mode codes
    localparam logic [2:0] M_PRESC  = 3'h0;
    localparam logic [2:0] M_WIDE   = 3'h1;
    localparam logic [2:0] M_RELOAD = 3'h2;
    localparam logic [2:0] M_SPLIT  = 3'h3;
    localparam logic [2:0] M_PWM    = 3'h6;

    localparam logic [4:0] PRESC_TOP = 5'h1F;
    localparam logic [7:0] BYTE_TOP  = 8'hFF;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;
endpackage : dtc_pkg

/* hw/dtc_timers.sv */
// Two timer/counters with an AHB-Lite register slave.
// Assumes count and gate pins are asynchronous; bus on hclk.
`timescale 1ns/1ps
`default_nettype none

module dtc_timers (
    // Clock, reset, enable
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        clk_en,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Timer 0 pins
    input  wire logic        count_pin_zero_i,
    output logic             count_pin_zero_o,
    output logic             count_pin_zero_oe,
    input  wire logic        gate_pin_zero,
    // Timer 1 pins
    input  wire logic        count_pin_one_i,
    output logic             count_pin_one_o,
    output logic             count_pin_one_oe,
    input  wire logic        gate_pin_one
);

    ////////////////////////////////////////////////////////////////////////
    // State

    logic [7:0]  mode_ff;
    logic [7:0]  aux_ff;
    logic [1:0]  run_ff;
    logic [1:0]  flag_ff;
    logic [1:0]  ten_ff;
    logic [7:0]  low_ff   [2];
    logic [7:0]  high_ff  [2];
    logic [1:0]  tog_ff;
    logic [1:0]  pin_o_ff;
    logic [1:0]  pin_oe_ff;

    logic [1:0]  cnt_s1_ff;
    logic [1:0]  cnt_s2_ff;
    logic [1:0]  gte_s1_ff;
    logic [1:0]  gte_s2_ff;
    logic [1:0]  samp_ff;
    logic [1:0]  prev_ff;
    logic        mc_ff;

    logic        wr_pend_ff;
    logic        rd_pend_ff;
    logic [7:0]  idx_ff;
    logic        ok_ff;
    logic [31:0] hrdata_ff;
    logic        hreadyout_ff;

    logic [7:0]  nxt_low   [2];
    logic [7:0]  nxt_high  [2];
    logic [1:0]  nxt_flag;
    logic [1:0]  nxt_tog;
    logic [1:0]  ovf;
    logic [1:0]  pwm_lvl;
    logic [1:0]  is_pwm;
    logic [1:0]  edge_det;
    logic        tick;
    logic        addr_ok;
    logic        wr_now;
    logic [7:0]  wbyte;

    ////////////////////////////////////////////////////////////////////////
    // One counting step: returns {overflow, high, low}

    function automatic logic [16:0] dtc_step(
        input logic [2:0] mode,
        input logic       inc,
        input logic [7:0] high,
        input logic [7:0] low
    );
        logic [12:0] c13;
        logic [15:0] c16;
        logic [16:0] res;
        c13 = {high, low[4:0]};
        c16 = {high, low};
        res = {1'b0, high, low};
        if (inc) begin
            unique case (mode)
                dtc_pkg::M_PRESC: begin
                    // Upper three low bits are left alone
                    c13 = c13 + 13'h0001;
                    res = {(high == dtc_pkg::BYTE_TOP) &&
                           (low[4:0] == dtc_pkg::PRESC_TOP),
                           c13[12:5], low[7:5], c13[4:0]};
                end
                dtc_pkg::M_WIDE: begin
                    c16 = c16 + 16'h0001;
                    res = {(c16 == 16'h0000), c16};
                end
                dtc_pkg::M_RELOAD: begin
                    if (low == dtc_pkg::BYTE_TOP) begin
                        res = {1'b1, high, high};
                    end else begin
                        res = {1'b0, high, low + 8'h01};
                    end
                end
                dtc_pkg::M_SPLIT: begin
                    res = {(low == dtc_pkg::BYTE_TOP), high,
                           low + 8'h01};
                end
                dtc_pkg::M_PWM: begin
                    res = {(low == dtc_pkg::BYTE_TOP), high,
                           low + 8'h01};
                end
                default: begin
                    // Reserved codes hold the count
                    res = {1'b0, high, low};
                end
            endcase
        end
        return res;
    endfunction : dtc_step

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and machine-cycle sampling

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_s1_ff <= 2'h0;
            cnt_s2_ff <= 2'h0;
            gte_s1_ff <= 2'h0;
            gte_s2_ff <= 2'h0;
        end else if (clk_en) begin
            cnt_s1_ff <= {count_pin_one_i, count_pin_zero_i};
            cnt_s2_ff <= cnt_s1_ff;
            gte_s1_ff <= {gate_pin_one, gate_pin_zero};
            gte_s2_ff <= gte_s1_ff;
        end
    end

    // Machine cycle is two clocks; tick marks its last clock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mc_ff <= 1'b0;
        end else if (clk_en) begin
            mc_ff <= ~mc_ff;
        end
    end
    assign tick = mc_ff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            samp_ff <= 2'h0;
            prev_ff <= 2'h0;
        end else if (clk_en && tick) begin
            samp_ff <= cnt_s2_ff;
            prev_ff <= samp_ff;
        end
    end

    // High then low over two samples; the count lands on this tick,
    // one machine cycle after the low sample was taken
    assign edge_det = prev_ff & ~samp_ff;

    ////////////////////////////////////////////////////////////////////////
    // Bus slave: writes commit at the end of the data phase, reads
    // take one wait state so they always see committed writes

    assign addr_ok = (haddr[1:0] == 2'h0) && (haddr[31:10] == 22'h0) &&
                     (hsize == dtc_pkg::HSIZE_WORD);
    assign wr_now  = wr_pend_ff && ok_ff;
    assign wbyte   = hwdata[7:0];

    function automatic logic [7:0] dtc_read(input logic [7:0] idx);
        logic [7:0] v;
        v = 8'h00;
        unique case (idx)
            dtc_pkg::IDX_CTRL:  v = {flag_ff[1], run_ff[1], flag_ff[0],
                                     run_ff[0], 2'h0, ten_ff};
            dtc_pkg::IDX_MODE:  v = mode_ff;
            dtc_pkg::IDX_AUX:   v = aux_ff & dtc_pkg::AUX_MASK;
            dtc_pkg::IDX_LOW0:  v = low_ff[0];
            dtc_pkg::IDX_LOW1:  v = low_ff[1];
            dtc_pkg::IDX_HIGH0: v = high_ff[0];
            dtc_pkg::IDX_HIGH1: v = high_ff[1];
            default:            v = 8'h00;
        endcase
        return v;
    endfunction : dtc_read

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff   <= 1'b0;
            rd_pend_ff   <= 1'b0;
            idx_ff       <= 8'h00;
            ok_ff        <= 1'b0;
            hrdata_ff    <= 32'h0000_0000;
            hreadyout_ff <= 1'b1;
        end else if (clk_en) begin
            wr_pend_ff <= 1'b0;
            if (rd_pend_ff) begin
                hrdata_ff    <= {24'h00_0000, ok_ff ? dtc_read(idx_ff)
                                                    : 8'h00};
                hreadyout_ff <= 1'b1;
                rd_pend_ff   <= 1'b0;
            end else if (hsel && hready &&
                         htrans == dtc_pkg::HTRANS_NONSEQ) begin
                idx_ff     <= haddr[9:2];
                ok_ff      <= addr_ok;
                wr_pend_ff <= hwrite;
                if (!hwrite) begin
                    rd_pend_ff   <= 1'b1;
                    hreadyout_ff <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_ff <= dtc_pkg::MODE_RST;
            aux_ff  <= dtc_pkg::AUX_RST;
            run_ff  <= 2'h0;
            ten_ff  <= 2'h0;
        end else if (clk_en && wr_now) begin
            unique case (idx_ff)
                dtc_pkg::IDX_MODE: mode_ff <= wbyte;
                dtc_pkg::IDX_AUX:  aux_ff  <= wbyte & dtc_pkg::AUX_MASK;
                dtc_pkg::IDX_CTRL: begin
                    run_ff <= {wbyte[dtc_pkg::CTRL_RUN1_POS],
                               wbyte[dtc_pkg::CTRL_RUN0_POS]};
                    ten_ff <= {wbyte[dtc_pkg::CTRL_TEN1_POS],
                               wbyte[dtc_pkg::CTRL_TEN0_POS]};
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counting

    always_comb begin
        logic [2:0]  md;
        logic        en;
        logic        inc;
        logic [16:0] st;
        logic        split0;
        logic [7:0]  hb;
        md     = 3'h0;
        en     = 1'b0;
        inc    = 1'b0;
        st     = 17'h0_0000;
        hb     = 8'h00;
        split0 = ({aux_ff[dtc_pkg::AUX_M2_POS],
                   mode_ff[dtc_pkg::MODE_LO_POS +: 2]} == dtc_pkg::M_SPLIT);
        for (int n = 0; n < 2; n++) begin
            md = {aux_ff[dtc_pkg::AUX_M2_POS + n * dtc_pkg::TIMER_STRIDE],
                  mode_ff[dtc_pkg::MODE_LO_POS +
                          n * dtc_pkg::TIMER_STRIDE +: 2]};
            en = run_ff[n] &&
                 (!mode_ff[dtc_pkg::GATE_POS + n * dtc_pkg::TIMER_STRIDE]
                  || gte_s2_ff[n]);
            inc = en && (mode_ff[dtc_pkg::FSEL_POS +
                                 n * dtc_pkg::TIMER_STRIDE]
                         ? (tick && edge_det[n])
                         : tick);
            if (n == 1 && md == dtc_pkg::M_SPLIT) begin
                inc = 1'b0;
            end
            st = dtc_step(md, inc, high_ff[n], low_ff[n]);
            ovf[n]      = st[16];
            nxt_high[n] = st[15:8];
            nxt_low[n]  = st[7:0];
            is_pwm[n]   = (md == dtc_pkg::M_PWM);
            // Low while low byte is under the high byte
            hb = high_ff[n];
            pwm_lvl[n] = (hb != dtc_pkg::BYTE_TOP) &&
                         (low_ff[n] >= hb);
        end
        // Split mode: high byte of timer 0 is a plain timer on run 1
        if (split0) begin
            nxt_high[0] = high_ff[0] +
                          ((run_ff[1] && tick) ? 8'h01 : 8'h00);
            ovf[1] = run_ff[1] && tick && (high_ff[0] == dtc_pkg::BYTE_TOP);
        end
    end

    // Overflow flags: hardware set beats a software clear
    always_comb begin
        for (int n = 0; n < 2; n++) begin
            nxt_flag[n] = flag_ff[n];
            if (wr_now && idx_ff == dtc_pkg::IDX_CTRL) begin
                nxt_flag[n] = (n == 0) ? wbyte[dtc_pkg::CTRL_FLG0_POS]
                                       : wbyte[dtc_pkg::CTRL_FLG1_POS];
            end
            if (ovf[n]) begin
                nxt_flag[n] = 1'b1;
            end
            if (is_pwm[n]) begin
                nxt_flag[n] = pwm_lvl[n];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_ff <= 2'h0;
        end else if (clk_en) begin
            flag_ff <= nxt_flag;
        end
    end

    // Software writes to a count byte win over counting
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            low_ff[0]  <= dtc_pkg::COUNT_RST;
            low_ff[1]  <= dtc_pkg::COUNT_RST;
            high_ff[0] <= dtc_pkg::COUNT_RST;
            high_ff[1] <= dtc_pkg::COUNT_RST;
        end else if (clk_en) begin
            low_ff[0]  <= (wr_now && idx_ff == dtc_pkg::IDX_LOW0)
                          ? wbyte : nxt_low[0];
            low_ff[1]  <= (wr_now && idx_ff == dtc_pkg::IDX_LOW1)
                          ? wbyte : nxt_low[1];
            high_ff[0] <= (wr_now && idx_ff == dtc_pkg::IDX_HIGH0)
                          ? wbyte : nxt_high[0];
            high_ff[1] <= (wr_now && idx_ff == dtc_pkg::IDX_HIGH1)
                          ? wbyte : nxt_high[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin outputs: PWM level, or toggle on overflow

    // Toggling needs the internal clock source
    always_comb begin
        for (int n = 0; n < 2; n++) begin
            nxt_tog[n] = tog_ff[n];
            if (!ten_ff[n] ||
                mode_ff[dtc_pkg::FSEL_POS + n * dtc_pkg::TIMER_STRIDE])
            begin
                nxt_tog[n] = 1'b1;
            end else if (ovf[n]) begin
                nxt_tog[n] = ~tog_ff[n];
            end
        end
    end

    // Pin takes the next toggle value, so outside PWM mode dropping the enable
    // leaves it high; PWM level only once the drive already stands
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tog_ff    <= 2'h3;
            pin_o_ff  <= 2'h3;
            pin_oe_ff <= 2'h0;
        end else if (clk_en) begin
            tog_ff <= nxt_tog;
            for (int n = 0; n < 2; n++) begin
                pin_o_ff[n]  <= (is_pwm[n] && pin_oe_ff[n]) ? nxt_flag[n]
                                                            : nxt_tog[n];
                pin_oe_ff[n] <= is_pwm[n] || (ten_ff[n] &&
                    !mode_ff[dtc_pkg::FSEL_POS +
                             n * dtc_pkg::TIMER_STRIDE]);
            end
        end
    end

    assign hrdata            = hrdata_ff;
    assign hreadyout         = hreadyout_ff;
    assign hresp             = 1'b0 & hreadyout_ff;
    assign count_pin_zero_o  = pin_o_ff[0];
    assign count_pin_one_o   = pin_o_ff[1];
    assign count_pin_zero_oe = pin_oe_ff[0];
    assign count_pin_one_oe  = pin_oe_ff[1];

endmodule : dtc_timers

`default_nettype wire

/* dv/dtc_checker_assertions.sv */
// Checker for the timer block's bus handshake and pin outputs.
// Sees only the ports of dtc_timers; bound at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module dtc_checker (
    // Clock, reset, enable
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        clk_en,
    // Bus
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Pins
    input wire logic        count_pin_zero_o,
    input wire logic        count_pin_zero_oe,
    input wire logic        count_pin_one_o,
    input wire logic        count_pin_one_oe
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic take;
    assign take = hsel && hready && clk_en
                  && htrans == dtc_pkg::HTRANS_NONSEQ;
    ////////////////////////////////////////////////////////////////////////////
    property p_okay;
        hresp == 1'b0;
    endproperty
    a_okay: assert property (p_okay) else $error("response not OKAY");
    property p_rd_wait;
        (take && !hwrite) ##1 clk_en |-> !hreadyout ##1 hreadyout;
    endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
    property p_wr_fast;
        (take && hwrite) |=> hreadyout;
    endproperty
    a_wr_fast: assert property (p_wr_fast) else $error("write stalled");
    property p_rd_upper;
        hrdata[31:8] == 24'h0;
    endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("upper data set");
    // Read data must survive writes and idle cycles
    property p_rd_hold;
        hreadyout && $past(hreadyout) |-> $stable(hrdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    property p_freeze;
        !clk_en |=> $stable(hrdata) && $stable(hreadyout)
                    && $stable(count_pin_zero_o) && $stable(count_pin_one_o);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved frozen");
    property p_tgl_start;
        $rose(count_pin_zero_oe) |-> count_pin_zero_o;
    endproperty
    a_tgl_start: assert property (p_tgl_start) else $error("toggle start low");
    property p_idle0;
        !count_pin_zero_oe |-> count_pin_zero_o;
    endproperty
    a_idle0: assert property (p_idle0) else $error("pin zero idle low");
    property p_idle1;
        !count_pin_one_oe |-> count_pin_one_o;
    endproperty
    a_idle1: assert property (p_idle1) else $error("pin one idle low");
    c_read: cover property (take && !hwrite);
    c_toggle: cover property ($rose(count_pin_zero_oe));
    c_freeze: cover property (!clk_en);
endmodule : dtc_checker
bind dtc_timers dtc_checker dtc_checker_i (
    .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp),
    .count_pin_zero_o(count_pin_zero_o), .count_pin_zero_oe(count_pin_zero_oe),
    .count_pin_one_o(count_pin_one_o), .count_pin_one_oe(count_pin_one_oe)
);
`default_nettype wire

/* dv/dtc_pin_model.sv */
// External event source and gate drivers for both timers.
// Assumes its tasks are called just after a rising edge of hclk.
`timescale 1ns/1ps
`default_nettype none
module dtc_pin_model (
    // Clock
    input  wire logic       hclk,
    // Design pin drive
    input  wire logic [1:0] pin_o,
    input  wire logic [1:0] pin_oe,
    // Resolved levels
    output logic      [1:0] count_lvl,
    output logic      [1:0] gate_lvl
);
    logic [1:0] src;
    // Design drive wins while its enable is high
    assign count_lvl = (pin_oe & pin_o) | (~pin_oe & src);
    initial begin
        src      = 2'h3;
        gate_lvl = 2'h0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Four clocks a level: one machine cycle plus synchroniser slack
    task automatic pulses(input int t, input int n);
        repeat (n) begin
            src[t] <= 1'b0;
            repeat (4) @(posedge hclk);
            src[t] <= 1'b1;
            repeat (4) @(posedge hclk);
        end
    endtask : pulses
    task automatic gate_hold(input int t, input int n);
        gate_lvl[t] <= 1'b1;
        repeat (n) @(posedge hclk);
        gate_lvl[t] <= 1'b0;
    endtask : gate_hold
endmodule : dtc_pin_model
`default_nettype wire

/* dv/test_dtc_timers.sv */
// Self-checking bench for dtc_timers over AHB-Lite.
// Assumes dtc_pin_model drives the count and gate pins.
`timescale 1ns/1ps
`default_nettype none
module test_dtc_timers;
    logic            hclk, hresetn, clk_en, hsel, hwrite;
    logic [1:0]      htrans;
    logic [2:0]      hsize;
    logic [31:0]     haddr, hwdata, hrdata, rv;
    logic            hready, hreadyout, hresp;
    wire logic [1:0] po, poe, cnt, gate;
    int              miscompares, n_compared;
    logic [7:0]      regs [8];
    logic [2:0]      modes [5];
    always #12.5 hclk = ~hclk;
    assign hready = hreadyout;
    dtc_timers dtc_timers_i (
        .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp),
        .count_pin_zero_i(cnt[0]), .count_pin_zero_o(po[0]),
        .count_pin_zero_oe(poe[0]), .gate_pin_zero(gate[0]),
        .count_pin_one_i(cnt[1]), .count_pin_one_o(po[1]),
        .count_pin_one_oe(poe[1]), .gate_pin_one(gate[1])
    );
    dtc_pin_model dtc_pin_model_i (
        .hclk(hclk), .pin_o(po), .pin_oe(poe),
        .count_lvl(cnt), .gate_lvl(gate)
    );
    ////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        if (miscompares == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 64);
        if (hreadyout !== 1'b1) begin
            miscompares++;
            conclude();
        end
    endtask : wait_ready
    task automatic bus(input logic wr, input logic [7:0] idx,
                       input logic [7:0] wd);
        hsel   <= 1'b1;
        haddr  <= {22'h0, idx, 2'h0};
        htrans <= dtc_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        hsize  <= dtc_pkg::HSIZE_WORD;
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        wait_ready();
        rv = hrdata;
    endtask : bus
    task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] idx);
        bus(1'b0, idx, 8'h00);
    endtask : reg_rd
    // Returns {flag, high, low} after k enabled machine cycles
    function automatic logic [16:0] adv(input logic [2:0] m, input logic t,
        input logic [7:0] h, input logic [7:0] l, input int k);
        logic f;
        f = 1'b0;
        for (int i = 0; i < k; i++) begin
            case (m)
                3'h0: begin
                    {h, l[4:0]} = {h, l[4:0]} + 13'h1;
                    f |= ({h, l[4:0]} == 13'h0);
                end
                3'h1: begin
                    {h, l} = {h, l} + 16'h1;
                    f |= ({h, l} == 16'h0);
                end
                3'h2: begin
                    f |= (l == 8'hFF);
                    l = (l == 8'hFF) ? h : l + 8'h1;
                end
                3'h3: begin
                    f |= !t && (l == 8'hFF);
                    l = t ? l : l + 8'h1;
                end
                default: l = l + 8'h1;
            endcase
        end
        if (m == 3'h6)
            f = (h != 8'hFF) && (l >= h);
        return {f, h, l};
    endfunction : adv
    task automatic run_gated(input int t, input logic [2:0] m,
                             input logic [7:0] h, input logic [7:0] l);
        logic [3:0]  nib;
        logic [7:0]  ilo, ihi;
        logic [16:0] e, got;
        nib = {2'h2, m[1:0]};
        ilo = t ? dtc_pkg::IDX_LOW1 : dtc_pkg::IDX_LOW0;
        ihi = t ? dtc_pkg::IDX_HIGH1 : dtc_pkg::IDX_HIGH0;
        reg_wr(dtc_pkg::IDX_CTRL, 8'h00);
        reg_wr(dtc_pkg::IDX_MODE, t ? {nib, 4'h0} : {4'h0, nib});
        reg_wr(dtc_pkg::IDX_AUX, {3'h0, m[2] & t[0], 3'h0, m[2] & !t[0]});
        reg_wr(ilo, l);
        reg_wr(ihi, h);
        reg_wr(dtc_pkg::IDX_CTRL, t ? 8'h40 : 8'h10);
        dtc_pin_model_i.gate_hold(t, 20);
        repeat (8) @(posedge hclk);
        reg_rd(ilo);
        got[7:0] = rv[7:0];
        reg_rd(ihi);
        got[15:8] = rv[7:0];
        reg_rd(dtc_pkg::IDX_CTRL);
        got[16] = t ? rv[7] : rv[5];
        // Twenty synced gate clocks give exactly ten machine cycles
        e = adv(m, t[0], h, l, 10);
        chk("count", {15'h0, e}, {15'h0, got});
        reg_wr(dtc_pkg::IDX_CTRL, 8'h00);
        dtc_pin_model_i.gate_hold(t, 20);
        repeat (8) @(posedge hclk);
        reg_rd(ilo);
        chk("held", {24'h0, got[7:0]}, rv);
    endtask : run_gated
    task automatic run_events(input int t);
        logic [7:0]  ilo, ihi, l;
        logic [15:0] seen;
        int          n;
        ilo = t ? dtc_pkg::IDX_LOW1 : dtc_pkg::IDX_LOW0;
        ihi = t ? dtc_pkg::IDX_HIGH1 : dtc_pkg::IDX_HIGH0;
        l = 8'($urandom);
        n = 3 + $urandom % 6;
        reg_wr(dtc_pkg::IDX_CTRL, 8'h00);
        reg_wr(dtc_pkg::IDX_MODE, t ? 8'h50 : 8'h05);
        reg_wr(dtc_pkg::IDX_AUX, 8'h00);
        reg_wr(ilo, l);
        reg_wr(ihi, 8'h00);
        reg_wr(dtc_pkg::IDX_CTRL, t ? 8'h40 : 8'h10);
        dtc_pin_model_i.pulses(t, n);
        repeat (12) @(posedge hclk);
        reg_rd(ilo);
        seen[7:0] = rv[7:0];
        reg_rd(ihi);
        seen[15:8] = rv[7:0];
        chk("events", {24'h0, l} + n, {16'h0, seen});
        reg_wr(dtc_pkg::IDX_CTRL, 8'h00);
    endtask : run_events
    initial begin
        logic [7:0] d;
        logic       last;
        int         n;
        hclk = 1'b0;
        hresetn = 1'b0;
        clk_en = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = dtc_pkg::HSIZE_WORD;
        hwdata = 32'h0;
        miscompares = 0;
        n_compared = 0;
        regs = '{dtc_pkg::IDX_CTRL, dtc_pkg::IDX_MODE, dtc_pkg::IDX_LOW0,
                 dtc_pkg::IDX_LOW1, dtc_pkg::IDX_HIGH0, dtc_pkg::IDX_HIGH1,
                 dtc_pkg::IDX_AUX, 8'h8E};
        modes = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6};
        void'($urandom(87));
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (regs[i]) begin
            reg_rd(regs[i]);
            chk("reset", 32'h0, rv);
        end
        reg_wr(8'h8E, 8'hA5);
        reg_rd(8'h8E);
        chk("unmapped", 32'h0, rv);
        reg_wr(dtc_pkg::IDX_AUX, 8'hFF);
        reg_rd(dtc_pkg::IDX_AUX);
        chk("aux", {24'h0, dtc_pkg::AUX_MASK}, rv);
        d = 8'($urandom);
        reg_wr(dtc_pkg::IDX_MODE, d);
        reg_rd(dtc_pkg::IDX_MODE);
        chk("mode", {24'h0, d}, rv);
        for (int t = 0; t < 2; t++) begin
            foreach (modes[j]) begin
                run_gated(t, modes[j], 8'($urandom), 8'($urandom));
                run_gated(t, modes[j], 8'hFF, 8'hFE);
            end
            run_events(t);
        end
        reg_wr(dtc_pkg::IDX_MODE, 8'h02);
        reg_wr(dtc_pkg::IDX_AUX, 8'h00);
        reg_wr(dtc_pkg::IDX_HIGH0, 8'hF0);
        reg_wr(dtc_pkg::IDX_LOW0, 8'hF0);
        reg_wr(dtc_pkg::IDX_CTRL, 8'h01);
        repeat (3) @(posedge hclk);
        chk("toggle idle", 32'h3, {30'h0, poe[0], po[0]});
        clk_en <= 1'b0;
        repeat (6) @(posedge hclk);
        clk_en <= 1'b1;
        reg_wr(dtc_pkg::IDX_CTRL, 8'h11);
        n = 0;
        last = po[0];
        // Reload every 16 machine cycles: ten toggles in 330 clocks
        repeat (330) begin
            @(posedge hclk);
            if (po[0] !== last)
                n++;
            last = po[0];
        end
        chk("toggles", 32'h0000_000A, n);
        conclude();
    end
endmodule : test_dtc_timers
`default_nettype wire
